// >>> verilog/pcl_pkg.sv
// Constants and types shared by both ends of the parallel loader link
// Functional notes
// - User mode: request, status, load-complete all high
// - Status held low through power-on delay
// - Load-complete low until loading finishes
// - Config clock ignored in user mode, kept driven
// - Wide mode uses bits 15..0, narrow 7..0
// - Data pins become user I/O afterwards
// - Load-complete released only after whole image
// - Host gives two falling edges after release
// - Init-done driven low once option bit loaded
// - Initialization lasts 8576 init clock cycles
// - Init clock: oscillator, user clock, config clock
// - Host uses selectable clocks-per-word ratio
package pcl_pkg;
	localparam int DATA_W = 32;
	localparam int WIDE_W = 16;
	localparam int NARROW_W = 8;
	localparam int CNT_W = 16;
	localparam int INIT_W = 14;
	localparam real SYS_MHZ = 250.0;
	localparam real OSC_MAX_MHZ = 12.5;
	localparam real CFG_CLK_MAX_MHZ = 125.0;
	localparam int OSC_DIV = int'($ceil(SYS_MHZ / OSC_MAX_MHZ));
	localparam int CFG_HALF = int'($ceil(SYS_MHZ / CFG_CLK_MAX_MHZ));
	localparam logic [4:0] OSC_DIV_LAST = 5'(OSC_DIV - 1);
	localparam logic [3:0] CFG_HALF_LAST = 4'(CFG_HALF - 1);
	localparam int INIT_CYCLES = 8576;
	localparam int POR_CYCLES = 64;
	localparam int IMAGE_WORDS = 16;
	localparam logic [3:0] RECONF_LOW_LAST = 4'h7;
	localparam logic [1:0] TAIL_FALLS = 2'h2;
	// Option word fields, first unit of the image
	localparam int OPT_INITDONE = 0;
	localparam int OPT_CLKSEL_LSB = 1;
	localparam int OPT_USERCLK = 3;
	localparam int OPT_USERIO = 4;
	typedef enum logic [1:0] {
		ICLK_OSC = 2'b00,
		ICLK_USER = 2'b01,
		ICLK_CFG = 2'b10
	} pcl_iclk_t;
	// Host register map and fields
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_COUNT = 8'h0C;
	localparam int CTRL_START = 0;
	localparam int CTRL_WIDE = 1;
	localparam int CTRL_RATIO_LSB = 2;
	localparam int ST_BUSY = 0;
	localparam int ST_STATUS = 1;
	localparam int ST_LOADED = 2;
	localparam int ST_INIT = 3;
	localparam int ST_FULL = 4;
	localparam int ST_ERR = 5;
	localparam int ST_DONE = 6;
endpackage

// >>> verilog/pcl_link_if.sv
// Link between the configuration host and the loaded device
`timescale 1ns/100ps
interface pcl_link_if;
	logic configClock;
	logic reconfigRequestN;
	logic statusNOut;
	logic statusNOe;
	logic loadCompleteOut;
	logic loadCompleteOe;
	logic initDoneOut;
	logic initDoneOe;
	logic [31:0] hostData;
	logic hostDataOe;
	logic [31:0] devData;
	logic devDataOe;
	logic configStatusN;
	logic loadComplete;
	logic initDone;
	logic [31:0] dataBus;
	// Open-drain lines with pull-ups; data bus reads zero when undriven
	assign configStatusN = statusNOe ? statusNOut : 1'b1;
	assign loadComplete = loadCompleteOe ? loadCompleteOut : 1'b1;
	assign initDone = initDoneOe ? initDoneOut : 1'b1;
	assign dataBus = hostDataOe ? hostData : (devDataOe ? devData : '0);
	modport device(input configClock, reconfigRequestN, dataBus,
		output statusNOut, statusNOe, loadCompleteOut, loadCompleteOe,
		output initDoneOut, initDoneOe, devData, devDataOe);
	modport host(output configClock, reconfigRequestN, hostData,
		output hostDataOe,
		input configStatusN, loadComplete, initDone);
endinterface

// >>> verilog/pcl_device.sv
// Device end: loads the image, then initializes into user mode
`timescale 1ns/100ps
module pcl_device #(
	parameter int IMAGE_WORDS = pcl_pkg::IMAGE_WORDS,
	parameter int INIT_CYCLES = pcl_pkg::INIT_CYCLES,
	parameter int POR_CYCLES = pcl_pkg::POR_CYCLES
) (
	// System clock, used as the internal oscillator
	input logic clk_sys,
	input logic sys_rst,
	// Link
	pcl_link_if.device link,
	// Straps and start-up clock pins
	input logic wideMode,
	input logic [1:0] wordRatio,
	input logic userStartupClock,
	// User side after configuration
	input logic [31:0] userIoOut,
	input logic userIoOe,
	output logic [31:0] userIoIn,
	output logic userMode,
	output logic [15:0] optionWord
);
	typedef enum logic [2:0] {
		S_POR = 3'b000,
		S_CLEAR = 3'b001,
		S_LOAD = 3'b010,
		S_TAIL = 3'b011,
		S_INIT = 3'b100,
		S_USER = 3'b101
	} pcl_dst_t;

	// System domain state
	typedef struct packed {
		pcl_dst_t st;
		logic [pcl_pkg::INIT_W-1:0] cnt;
		logic [4:0] oscDiv;
		logic [1:0] ncfgSync;
		logic [1:0] loadedSync;
		logic [1:0] goSync;
		logic [1:0] optSync;
		logic [2:0] tglSync;
		logic [2:0] uclkSync;
		logic [1:0] wideSync;
		logic [3:0] ratioSync;
		logic wide;
		logic [1:0] ratio;
		logic [31:0] ioMeta;
		logic [31:0] ioIn;
		logic [15:0] opt;
		logic optHeld;
		logic lnkClr;
		logic statusOe;
		logic doneOe;
		logic initOe;
		logic devOe;
		logic [31:0] devData;
		logic userMode;
	} pcl_dsys_t;

	// Link domain state, config clock rising edges
	typedef struct packed {
		logic [pcl_pkg::CNT_W-1:0] wordCnt;
		logic [1:0] ratioCnt;
		logic [15:0] optWord;
		logic optValid;
		logic loaded;
		logic cfgTgl;
	} pcl_dlnk_t;

	pcl_dsys_t s_r;
	pcl_dsys_t s_nxt;
	pcl_dlnk_t l_r;
	pcl_dlnk_t l_nxt;
	logic [1:0] fall_r;
	logic initGo;
	logic tick;
	logic [15:0] unitVal;
	pcl_pkg::pcl_iclk_t iclk;

	assign initGo = (fall_r == pcl_pkg::TAIL_FALLS);
	assign iclk = pcl_pkg::pcl_iclk_t'(s_r.opt[pcl_pkg::OPT_CLKSEL_LSB +: 2]);

	// Unit presented on the bus for the selected width
	always_comb begin
		if (s_r.wide) begin
			unitVal = link.dataBus[pcl_pkg::WIDE_W-1:0];
		end else begin
			unitVal = {8'h00, link.dataBus[pcl_pkg::NARROW_W-1:0]};
		end
	end

	// Link domain: capture one unit per ratio group
	always_comb begin
		l_nxt = l_r;
		if (!l_r.loaded) begin
			if (l_r.ratioCnt == s_r.ratio) begin
				l_nxt.ratioCnt = 2'h0;
				l_nxt.wordCnt = l_r.wordCnt + 16'h0001;
				if (l_r.wordCnt == 16'h0000) begin
					l_nxt.optWord = unitVal;
					l_nxt.optValid = 1'b1;
				end
				if (l_r.wordCnt == 16'(IMAGE_WORDS - 1)) begin
					l_nxt.loaded = 1'b1;
				end
			end else begin
				l_nxt.ratioCnt = l_r.ratioCnt + 2'h1;
			end
		end else if (initGo) begin
			l_nxt.cfgTgl = ~l_r.cfgTgl;
		end
	end

	// Link domain registers, cleared while a load is not allowed
	always_ff @(posedge link.configClock or posedge s_r.lnkClr) begin
		if (s_r.lnkClr) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	// Falling edges after the image is in
	always_ff @(negedge link.configClock or posedge s_r.lnkClr) begin
		if (s_r.lnkClr) begin
			fall_r <= 2'h0;
		end else if (l_r.loaded && !initGo) begin
			fall_r <= fall_r + 2'h1;
		end
	end

	// Selected initialization clock tick
	always_comb begin
		unique case (iclk)
			pcl_pkg::ICLK_USER: begin
				if (s_r.opt[pcl_pkg::OPT_USERCLK]) begin
					tick = s_r.uclkSync[1] & ~s_r.uclkSync[2];
				end else begin
					tick = (s_r.oscDiv == 5'h00);
				end
			end
			pcl_pkg::ICLK_CFG: tick = s_r.tglSync[1] ^ s_r.tglSync[2];
			default: tick = (s_r.oscDiv == 5'h00);
		endcase
	end

	// System domain sequencing
	always_comb begin
		s_nxt = s_r;
		s_nxt.ncfgSync = {s_r.ncfgSync[0], link.reconfigRequestN};
		s_nxt.loadedSync = {s_r.loadedSync[0], l_r.loaded};
		s_nxt.goSync = {s_r.goSync[0], initGo};
		s_nxt.optSync = {s_r.optSync[0], l_r.optValid};
		s_nxt.tglSync = {s_r.tglSync[1:0], l_r.cfgTgl};
		s_nxt.uclkSync = {s_r.uclkSync[1:0], userStartupClock};
		s_nxt.wideSync = {s_r.wideSync[0], wideMode};
		s_nxt.ratioSync = {s_r.ratioSync[1:0], wordRatio};
		// Straps taken only while the link side is cleared, so the
		// first unit already sees the right width and group size
		if (s_r.lnkClr) begin
			s_nxt.wide = s_r.wideSync[1];
			s_nxt.ratio = s_r.ratioSync[3:2];
		end
		s_nxt.ioMeta = link.dataBus;
		s_nxt.ioIn = s_r.ioMeta;
		if (s_r.oscDiv == 5'h00) begin
			s_nxt.oscDiv = pcl_pkg::OSC_DIV_LAST;
		end else begin
			s_nxt.oscDiv = s_r.oscDiv - 5'h01;
		end
		if (s_r.optSync[1] && !s_r.optHeld) begin
			s_nxt.opt = l_r.optWord; // Stable once its flag has crossed
			s_nxt.optHeld = 1'b1;
		end
		unique case (s_r.st)
			S_POR: begin
				if (s_r.cnt == 14'(POR_CYCLES - 1)) begin
					s_nxt.cnt = '0;
					s_nxt.st = S_CLEAR;
				end else begin
					s_nxt.cnt = s_r.cnt + 14'h0001;
				end
			end
			S_CLEAR: begin
				if (s_r.ncfgSync[1]) begin
					s_nxt.st = S_LOAD;
				end
			end
			S_LOAD: begin
				if (s_r.loadedSync[1]) begin
					s_nxt.st = S_TAIL;
				end
			end
			S_TAIL: begin
				if (s_r.goSync[1]) begin
					s_nxt.st = S_INIT;
					s_nxt.cnt = '0;
				end
			end
			S_INIT: begin
				if (tick) begin
					if (s_r.cnt == 14'(INIT_CYCLES - 1)) begin
						s_nxt.st = S_USER;
					end else begin
						s_nxt.cnt = s_r.cnt + 14'h0001;
					end
				end
			end
			S_USER: begin
			end
		endcase
		// A request low restarts from any state past power-on
		if (s_r.st != S_POR && !s_r.ncfgSync[1]) begin
			s_nxt.st = S_CLEAR;
			s_nxt.optHeld = 1'b0;
			s_nxt.opt = '0;
		end
		s_nxt.lnkClr = (s_nxt.st == S_POR) || (s_nxt.st == S_CLEAR);
		s_nxt.statusOe = s_nxt.lnkClr;
		s_nxt.doneOe = (s_nxt.st == S_POR) || (s_nxt.st == S_CLEAR) ||
			(s_nxt.st == S_LOAD);
		s_nxt.initOe = s_nxt.optHeld && s_nxt.opt[pcl_pkg::OPT_INITDONE] &&
			((s_nxt.st == S_LOAD) || (s_nxt.st == S_TAIL) ||
			(s_nxt.st == S_INIT));
		s_nxt.userMode = (s_nxt.st == S_USER);
		s_nxt.devOe = s_nxt.userMode && s_nxt.opt[pcl_pkg::OPT_USERIO] &&
			userIoOe;
		s_nxt.devData = userIoOut;
	end

	// System domain registers
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '{st: S_POR, lnkClr: 1'b1, statusOe: 1'b1,
				doneOe: 1'b1, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Pins and user outputs straight from flops
	assign link.statusNOut = 1'b0;
	assign link.statusNOe = s_r.statusOe;
	assign link.loadCompleteOut = 1'b0;
	assign link.loadCompleteOe = s_r.doneOe;
	assign link.initDoneOut = 1'b0;
	assign link.initDoneOe = s_r.initOe;
	assign link.devData = s_r.devData;
	assign link.devDataOe = s_r.devOe;
	assign userIoIn = s_r.ioIn;
	assign userMode = s_r.userMode;
	assign optionWord = s_r.opt;
endmodule

// >>> verilog/pcl_host.sv
// Host end: APB-driven loader that clocks the image into the device
`timescale 1ns/100ps
module pcl_host (
	// Clock and reset
	input logic clk_sys,
	input logic sys_rst,
	// APB slave
	input logic [7:0] paddr,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link
	pcl_link_if.host link
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_PULSE = 3'b001,
		H_WAITST = 3'b010,
		H_LOW = 3'b011,
		H_HIGH = 3'b100,
		H_TAIL = 3'b101,
		H_INIT = 3'b110
	} pcl_hst_t;

	typedef struct packed {
		pcl_hst_t st;
		logic [3:0] ph;
		logic clk;
		logic reqN;
		logic [31:0] dOut;
		logic dOe;
		logic placed;
		logic [15:0] hold;
		logic full;
		logic wide;
		logic [1:0] ratio;
		logic [1:0] ratioCnt;
		logic [1:0] falls;
		logic [15:0] words;
		logic [1:0] stSync;
		logic [1:0] ldSync;
		logic [1:0] inSync;
		logic err;
		logic done;
		logic rdy;
		logic slvErr;
		logic [31:0] rdata;
	} pcl_host_t;

	pcl_host_t h_r;
	pcl_host_t h_nxt;
	logic acc;
	logic dataWr;

	assign acc = psel && penable && h_r.rdy;
	assign dataWr = pwrite && (paddr == pcl_pkg::REG_DATA);

	always_comb begin
		h_nxt = h_r;
		h_nxt.stSync = {h_r.stSync[0], link.configStatusN};
		h_nxt.ldSync = {h_r.ldSync[0], link.loadComplete};
		h_nxt.inSync = {h_r.inSync[0], link.initDone};
		// APB answer; a data write waits for the holding word to drain
		h_nxt.rdy = psel && !h_r.rdy && !(dataWr && h_r.full);
		h_nxt.slvErr = 1'b0;
		h_nxt.rdata = '0;
		unique case (paddr)
			pcl_pkg::REG_CTRL: h_nxt.rdata = {28'h0, h_r.ratio, h_r.wide, 1'b0};
			pcl_pkg::REG_STATUS: h_nxt.rdata = {25'h0, h_r.done, h_r.err,
				h_r.full, h_r.inSync[1], h_r.ldSync[1], h_r.stSync[1],
				(h_r.st != H_IDLE)};
			pcl_pkg::REG_COUNT: h_nxt.rdata = {16'h0, h_r.words};
			pcl_pkg::REG_DATA: h_nxt.rdata = '0;
			default: h_nxt.slvErr = 1'b1;
		endcase
		// Phase timer for the generated config clock
		if (h_r.ph != 4'h0) begin
			h_nxt.ph = h_r.ph - 4'h1;
		end
		unique case (h_r.st)
			H_IDLE: begin
				h_nxt.clk = 1'b0; // Parked but driven
			end
			H_PULSE: begin
				h_nxt.reqN = 1'b0;
				if (h_r.ph == 4'h0 && !h_r.stSync[1]) begin
					h_nxt.reqN = 1'b1;
					h_nxt.st = H_WAITST;
				end
			end
			H_WAITST: begin
				if (h_r.stSync[1]) begin
					h_nxt.st = H_LOW;
					h_nxt.dOe = 1'b1;
				end
			end
			H_LOW: begin
				if (!h_r.stSync[1]) begin
					h_nxt.err = 1'b1;
					h_nxt.dOe = 1'b0;
					h_nxt.st = H_IDLE;
				end else if (h_r.full && !h_r.placed) begin
					// Data changes only while the clock is low
					h_nxt.dOut = h_r.wide ? {16'h0, h_r.hold} :
						{24'h0, h_r.hold[7:0]};
					h_nxt.placed = 1'b1;
					h_nxt.ph = pcl_pkg::CFG_HALF_LAST;
				end else if (h_r.placed && h_r.ph == 4'h0) begin
					h_nxt.clk = 1'b1;
					h_nxt.ph = pcl_pkg::CFG_HALF_LAST;
					h_nxt.st = H_HIGH;
				end else if (!h_r.full && h_r.ldSync[1]) begin
					h_nxt.dOe = 1'b0; // Pins go back to the device
					h_nxt.falls = 2'h0;
					h_nxt.st = H_TAIL;
				end
			end
			H_HIGH: begin
				if (h_r.ph == 4'h0) begin
					h_nxt.clk = 1'b0;
					h_nxt.ph = pcl_pkg::CFG_HALF_LAST;
					h_nxt.st = H_LOW;
					if (h_r.ratioCnt == h_r.ratio) begin
						h_nxt.ratioCnt = 2'h0;
						h_nxt.full = 1'b0;
						h_nxt.placed = 1'b0;
						h_nxt.words = h_r.words + 16'h0001;
					end else begin
						h_nxt.ratioCnt = h_r.ratioCnt + 2'h1;
					end
				end
			end
			H_TAIL, H_INIT: begin
				if (h_r.ph == 4'h0) begin
					h_nxt.clk = ~h_r.clk;
					h_nxt.ph = pcl_pkg::CFG_HALF_LAST;
					if (h_r.clk && h_r.st == H_TAIL) begin
						h_nxt.falls = h_r.falls + 2'h1;
						if (h_r.falls == pcl_pkg::TAIL_FALLS - 2'h1) begin
							h_nxt.st = H_INIT;
						end
					end
				end
				if (h_r.st == H_INIT && h_r.inSync[1] && !h_r.clk) begin
					h_nxt.done = 1'b1;
					h_nxt.st = H_IDLE;
				end
			end
			default: h_nxt.st = H_IDLE;
		endcase
		// Register writes take effect at the completing edge
		if (acc && pwrite && paddr == pcl_pkg::REG_DATA) begin
			h_nxt.hold = pwdata[15:0];
			h_nxt.full = 1'b1;
		end
		if (acc && pwrite && paddr == pcl_pkg::REG_CTRL) begin
			h_nxt.wide = pwdata[pcl_pkg::CTRL_WIDE];
			h_nxt.ratio = pwdata[pcl_pkg::CTRL_RATIO_LSB +: 2];
			if (pwdata[pcl_pkg::CTRL_START]) begin
				h_nxt.st = H_PULSE;
				h_nxt.ph = pcl_pkg::RECONF_LOW_LAST;
				h_nxt.clk = 1'b0;
				h_nxt.reqN = 1'b0;
				h_nxt.dOe = 1'b0;
				h_nxt.full = 1'b0;
				h_nxt.placed = 1'b0;
				h_nxt.ratioCnt = 2'h0;
				h_nxt.words = '0;
				h_nxt.err = 1'b0;
				h_nxt.done = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			h_r <= '{st: H_IDLE, reqN: 1'b1, wide: 1'b1, default: '0};
		end else begin
			h_r <= h_nxt;
		end
	end

	// Outputs straight from flops
	assign prdata = h_r.rdata;
	assign pready = h_r.rdy;
	assign pslverr = h_r.slvErr;
	assign link.configClock = h_r.clk;
	assign link.reconfigRequestN = h_r.reqN;
	assign link.hostData = h_r.dOut;
	assign link.hostDataOe = h_r.dOe;
endmodule

// >>> bench/pcl_link_props.sv
// Concurrent checks on the loader link between host and device
`timescale 1ns/100ps
module pcl_link_props #(
	parameter int IMAGE_WORDS = 4,
	parameter int INIT_CYCLES = 40,
	parameter int POR_CYCLES = 8
) (
	// Clock and reset
	input logic clk_sys,
	input logic sys_rst,
	// Link lines
	input logic configClock,
	input logic reconfigRequestN,
	input logic hostDataOe,
	input logic devDataOe,
	input logic configStatusN,
	input logic loadComplete,
	input logic initDone,
	input logic [31:0] dataBus
);
	int porCnt;
	int riseCnt;
	int sinceLoad;
	logic clkPrev;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// Cycles since reset, data clock rises, cycles since load
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			porCnt <= 0;
			riseCnt <= 0;
			sinceLoad <= 0;
			clkPrev <= 1'b0;
		end else begin
			clkPrev <= configClock;
			if (porCnt < POR_CYCLES)
				porCnt <= porCnt + 1;
			if (!reconfigRequestN)
				riseCnt <= 0;
			else if (configClock && !clkPrev && hostDataOe)
				riseCnt <= riseCnt + 1;
			if (!loadComplete)
				sinceLoad <= 0;
			else if (sinceLoad < INIT_CYCLES)
				sinceLoad <= sinceLoad + 1;
		end
	end
	chk_por_hold: assert property (porCnt < POR_CYCLES |->
		!configStatusN && !loadComplete) else $error("status early");
	chk_req_status: assert property ($fell(reconfigRequestN) |->
		##[1:12] !configStatusN) else $error("request not seen");
	chk_req_load: assert property ($fell(reconfigRequestN) |->
		##[1:12] !loadComplete) else $error("load flag kept");
	chk_data_stable: assert property ($rose(configClock) &&
		$past(hostDataOe) && hostDataOe |-> $stable(dataBus))
		else $error("data moved at capture");
	chk_image_whole: assert property ($rose(loadComplete) |->
		riseCnt >= IMAGE_WORDS) else $error("load flag before image");
	chk_init_length: assert property ($rose(initDone) |->
		sinceLoad >= INIT_CYCLES) else $error("init too short");
	chk_init_drop: assert property ($fell(initDone) |->
		!loadComplete) else $error("init flag fell after load");
	chk_init_after: assert property ($rose(initDone) |->
		loadComplete && configStatusN) else $error("init done early");
	chk_user_pins: assert property (devDataOe |-> !hostDataOe)
		else $error("bus driven twice");
endmodule

// >>> bench/parallel_config_loader_tb.sv
// Self-checking bench: host and device joined over the link
`timescale 1ns/100ps
module parallel_config_loader_tb;
	localparam int IMG = 4;
	localparam int INIT = 40;
	localparam int POR = 8;
	localparam logic [15:0] OPTS [4] = '{16'h0015, 16'hF001, 16'hA50B,
		16'h3C02};
	localparam logic [3:0] WIDE = 4'h5;
	localparam logic [1:0] RATIO [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
	typedef struct {logic err; logic [31:0] data;} pcl_note_t;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic chkRead = 1'b0;
	logic wideMode = 1'b1;
	logic [1:0] wordRatio = 2'h0;
	logic userStartupClock = 1'b0;
	logic [31:0] userIoOut = 32'h0;
	logic userIoOe = 1'b0;
	logic [31:0] userIoIn;
	logic userMode;
	logic umPrev = 1'b0;
	logic [15:0] optionWord;
	int badCount = 0;
	int samplesChecked = 0;
	int seed = 97;
	pcl_note_t note;
	pcl_note_t readQ[$];
	logic [15:0] optQ[$];
	pcl_link_if link();
	pcl_device #(.IMAGE_WORDS(IMG), .INIT_CYCLES(INIT), .POR_CYCLES(POR))
	u_pcl_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
		.wideMode(wideMode), .wordRatio(wordRatio),
		.userStartupClock(userStartupClock), .userIoOut(userIoOut),
		.userIoOe(userIoOe), .userIoIn(userIoIn), .userMode(userMode),
		.optionWord(optionWord));
	pcl_host u_pcl_host (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	pcl_link_props #(.IMAGE_WORDS(IMG), .INIT_CYCLES(INIT),
		.POR_CYCLES(POR)) u_pcl_link_props (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .configClock(link.configClock),
		.reconfigRequestN(link.reconfigRequestN),
		.hostDataOe(link.hostDataOe), .devDataOe(link.devDataOe),
		.configStatusN(link.configStatusN),
		.loadComplete(link.loadComplete), .initDone(link.initDone),
		.dataBus(link.dataBus));
	// Clocks: system and free-running start-up clock
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) userStartupClock <= ~userStartupClock;
	task automatic check(input string what, input logic [31:0] expVal,
		input logic [31:0] got);
		samplesChecked++;
		if (got !== expVal) begin
			badCount++;
			$display("[FAIL] %s expected %h seen %h", what, expVal, got);
		end
	endtask
	// One APB transfer, waits for pready under a bound
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic chk, output logic [31:0] rd);
		int n;
		@(posedge clk_sys);
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		psel <= 1'b1;
		chkRead <= chk;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 3000);
		if (n >= 3000)
			badCount++;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		chkRead <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		apb(1'b1, a, d, 1'b0, x);
	endtask
	task automatic rdChk(input logic [7:0] a, input logic err,
		input logic [31:0] d);
		logic [31:0] x;
		readQ.push_back('{err, d});
		apb(1'b0, a, 32'h0, 1'b1, x);
	endtask
	// Monitor: read answers and option word at entry to user mode
	always @(posedge clk_sys) begin
		umPrev <= userMode;
		if (psel && penable && pready === 1'b1 && !pwrite && chkRead) begin
			note = readQ.pop_front();
			check("pslverr", {31'h0, note.err}, {31'h0, pslverr});
			if (!note.err)
				check("prdata", note.data, prdata);
		end
		if (userMode === 1'b1 && umPrev === 1'b0)
			check("optionWord", {16'h0, optQ.pop_front()},
				{16'h0, optionWord});
	end
	task summarize;
		$display("checked %0d mismatched %0d", samplesChecked, badCount);
		if (badCount == 0 && samplesChecked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Watchdog, several times the expected run length
	initial begin
		#100000;
		badCount++;
		summarize();
	end
	// Four loads: width, ratio and init clock source each varied
	initial begin
		logic [31:0] st;
		logic [31:0] expVal;
		logic [15:0] opt;
		logic [15:0] unit;
		int i;
		int k;
		int w;
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (i = 0; i < 4; i++) begin
			opt = OPTS[i];
			wideMode <= WIDE[i];
			wordRatio <= RATIO[i];
			optQ.push_back(WIDE[i] ? opt : {8'h00, opt[7:0]});
			wr(pcl_pkg::REG_CTRL, {28'h0, RATIO[i], WIDE[i], 1'b1});
			for (k = 0; k < IMG; k++) begin
				w = $random(seed);
				unit = (k == 0) ? opt : w[15:0];
				wr(pcl_pkg::REG_DATA, {16'h0, unit});
			end
			k = 0;
			do begin
				apb(1'b0, pcl_pkg::REG_STATUS, 32'h0, 1'b0, st);
				k++;
			end while (st[pcl_pkg::ST_DONE] !== 1'b1 && k < 400);
			check("done", 32'h1, {31'h0, st[pcl_pkg::ST_DONE]});
			rdChk(pcl_pkg::REG_STATUS, 1'b0, 32'h0000004E);
			rdChk(pcl_pkg::REG_COUNT, 1'b0, 32'(IMG));
			k = 0;
			while (userMode !== 1'b1 && k < 2000) begin
				@(posedge clk_sys);
				k++;
			end
			check("userMode", 32'h1, {31'h0, userMode});
			userIoOut <= $random(seed);
			userIoOe <= 1'b1;
			repeat (6) @(posedge clk_sys);
			expVal = opt[pcl_pkg::OPT_USERIO] ? userIoOut : 32'h0;
			check("dataBus", expVal, link.dataBus);
			check("userIoIn", expVal, userIoIn);
			$display("load %0d finished", i);
		end
		rdChk(8'h10, 1'b1, 32'h0);
		rdChk(pcl_pkg::REG_DATA, 1'b0, 32'h0);
		$display("bus checks finished");
		summarize();
	end
endmodule
